// *** logic/rbs_core.sv ***
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rbs_defs.svh"
module rbs_core #(
   parameter int PC_W = 21,
   parameter int AW   = 12
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic                awready_q, awready_d, wready_q, wready_d;
   logic                bvalid_q, bvalid_d, arready_q, arready_d;
   logic                rvalid_q, rvalid_d, rpend_q, rpend_d;
   logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
   logic [7:0]          awaddr_q, awaddr_d, araddr_q, araddr_d;
   logic [31:0]         wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0]          wstrb_q, wstrb_d;
   rbs_pkg::rbs_state_e state_q, state_d;
   logic [1:0]          ph_q, ph_d;
   logic [15:0]         ir_q, ir_d;
   logic [PC_W-1:0]     pc_q, pc_d;
   logic [2:0]          flags_q, flags_d;
   logic [3:0]          bank_q, bank_d;
   logic [AW-1:0]       faddr_q, faddr_d;
   logic                taken_q, taken_d;
   logic [7:0]          cyc_q, cyc_d, mod_q, mod_d;
   logic                wr_go, busy, take, is_set;
   logic [10:0]         off;
   logic [31:0]         wval, rval;
   logic                rerr;

   rbs_dmem_if #(.AW(AW)) dm ();

   rbs_dmem #(
      .AW   (AW)
   ) u_dmem (
      .aclk (aclk),
      .port (dm)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // byte-lane merge of a write into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // incremented address plus twice the signed offset
   function automatic logic [PC_W-1:0] rel_add(input logic [PC_W-1:0] pc,
                                               input logic [10:0] o);
      return pc + {{(PC_W-12){o[10]}}, o, 1'b0};
   endfunction

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign busy   = (state_q != rbs_pkg::st_idle);
   assign is_set = (ir_q[15:12] == `RBS_OP_SETBIT);
   assign off    = (ir_q[15:11] == `RBS_OP_ALWAYS) ? ir_q[10:0]
                                                   : {{3{ir_q[7]}}, ir_q[7:0]};

   // branch condition from opcode and flags
   always_comb
   begin
      take = 1'b0;
      if (ir_q[15:8] == `RBS_OP_NOTNEG)
      begin
         take = !flags_q[`RBS_FLG_N];
      end
      else if (ir_q[15:8] == `RBS_OP_NOTOV)
      begin
         take = !flags_q[`RBS_FLG_OV];
      end
      else if (ir_q[15:8] == `RBS_OP_NOTZERO)
      begin
         take = !flags_q[`RBS_FLG_Z];
      end
      else if (ir_q[15:11] == `RBS_OP_ALWAYS)
      begin
         take = 1'b1;
      end
   end

   // ----------------------------------------
   // file register port
   // ----------------------------------------
   // sequencer owns the port while busy, bus window otherwise
   always_comb
   begin
      dm.wr    = 1'b0;
      dm.wdata = mod_q;
      dm.addr  = faddr_q;
      if (busy)
      begin
         if (ir_q[8])
         begin
            dm.addr = {bank_q, ir_q[7:0]};
         end
         else if (ir_q[7:0] < `RBS_ACC_SPLIT)
         begin
            dm.addr = {4'h0, ir_q[7:0]};
         end
         else
         begin
            dm.addr = {`RBS_ACC_HI_BANK, ir_q[7:0]};
         end
         dm.wr = (state_q == rbs_pkg::st_run) && (ph_q == 2'h3) && is_set;
      end
      else if (wr_go && (awaddr_q == `RBS_OFS_FDATA) && wstrb_q[0])
      begin
         dm.wr    = 1'b1;
         dm.wdata = wdata_q[7:0];
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb
   begin
      rerr = 1'b0;
      rval = 32'h0000_0000;
      case (araddr_q)
         `RBS_OFS_INSTR: rval = {16'h0000, ir_q};
         `RBS_OFS_PC:    rval = {{(32-PC_W){1'b0}}, pc_q};
         `RBS_OFS_FLAGS: rval = {29'h0000_0000, flags_q};
         `RBS_OFS_BANK:  rval = {28'h000_0000, bank_q};
         `RBS_OFS_STAT:  rval = {16'h0000, cyc_q, 6'h00, taken_q, busy};
         `RBS_OFS_FADDR: rval = {{(32-AW){1'b0}}, faddr_q};
         `RBS_OFS_FDATA:
         begin
            rval = {24'h00_0000, dm.rdata};
            rerr = busy;
         end
         default:        rerr = 1'b1;
      endcase
   end

   // ----------------------------------------
   // bus and sequencer next state
   // ----------------------------------------
   assign wr_go = !awready_q && !wready_q && !bvalid_q;

   always_comb
   begin
      awready_d = awready_q;
      wready_d  = wready_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      arready_d = arready_q;
      araddr_d  = araddr_q;
      rpend_d   = rpend_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      state_d   = state_q;
      ph_d      = ph_q;
      ir_d      = ir_q;
      pc_d      = pc_q;
      flags_d   = flags_q;
      bank_d    = bank_q;
      faddr_d   = faddr_q;
      taken_d   = taken_q;
      cyc_d     = cyc_q;
      mod_d     = mod_q;
      wval      = merge(32'h0000_0000, wdata_q, wstrb_q);
      // write address and data taken in either order
      if (awvalid && awready_q)
      begin
         awaddr_d  = awaddr;
         awready_d = 1'b0;
      end
      if (wvalid && wready_q)
      begin
         wdata_d  = wdata;
         wstrb_d  = wstrb;
         wready_d = 1'b0;
      end
      if (bvalid_q && bready)
      begin
         bvalid_d  = 1'b0;
         awready_d = 1'b1;
         wready_d  = 1'b1;
      end
      // read: address, then one cycle for the file register port
      if (arvalid && arready_q)
      begin
         araddr_d  = araddr;
         arready_d = 1'b0;
         rpend_d   = 1'b1;
      end
      if (rpend_q)
      begin
         rpend_d  = 1'b0;
         rvalid_d = 1'b1;
         rdata_d  = rerr ? 32'h0000_0000 : rval;
         rresp_d  = rerr ? `RBS_RESP_SLV : `RBS_RESP_OKAY;
      end
      if (rvalid_q && rready)
      begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
      // instruction sequencer, one aclk per phase
      case (state_q)
         rbs_pkg::st_run:
         begin
            ph_d = ph_q + 2'h1;
            case (ph_q)
               2'h0: pc_d = pc_q + PC_W'(`RBS_PC_STEP);
               2'h2: mod_d = dm.rdata | (8'h01 << ir_q[11:9]);
               2'h3:
               begin
                  taken_d = take;
                  cyc_d   = 8'h01;
                  state_d = rbs_pkg::st_idle;
                  if (take)
                  begin
                     pc_d    = rel_add(pc_q, off);
                     cyc_d   = 8'h02;
                     state_d = rbs_pkg::st_nop;
                  end
               end
               default: ;
            endcase
         end
         rbs_pkg::st_nop:
         begin
            ph_d = ph_q + 2'h1;
            if (ph_q == 2'h3)
            begin
               state_d = rbs_pkg::st_idle;
            end
         end
         default:
         begin
            ph_d = 2'h0;
         end
      endcase
      // register writes; rejected while an instruction runs
      if (wr_go)
      begin
         bvalid_d = 1'b1;
         bresp_d  = `RBS_RESP_OKAY;
         if (busy)
         begin
            bresp_d = `RBS_RESP_SLV;
         end
         else
         begin
            case (awaddr_q)
               `RBS_OFS_INSTR:
               begin
                  ir_d    = 16'(merge({16'h0000, ir_q}, wdata_q, wstrb_q));
                  state_d = rbs_pkg::st_run;
                  ph_d    = 2'h0;
               end
               `RBS_OFS_PC:    pc_d    = wval[PC_W-1:0];
               `RBS_OFS_FLAGS: flags_d = wval[2:0];
               `RBS_OFS_BANK:  bank_d  = wval[3:0];
               `RBS_OFS_FADDR: faddr_d = wval[AW-1:0];
               `RBS_OFS_FDATA: ;
               `RBS_OFS_STAT:  ;
               default:        bresp_d = `RBS_RESP_SLV;
            endcase
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RBS_RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         arready_q <= 1'b1;
         araddr_q  <= 8'h00;
         rpend_q   <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `RBS_RESP_OKAY;
         state_q   <= rbs_pkg::st_idle;
         ph_q      <= 2'h0;
         ir_q      <= 16'h0000;
         pc_q      <= PC_W'(`RBS_RST_PC);
         flags_q   <= `RBS_RST_FLAGS;
         bank_q    <= `RBS_RST_BANK;
         faddr_q   <= `RBS_RST_FADDR;
         taken_q   <= 1'b0;
         cyc_q     <= 8'h00;
         mod_q     <= 8'h00;
      end
      else
      begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         arready_q <= arready_d;
         araddr_q  <= araddr_d;
         rpend_q   <= rpend_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         state_q   <= state_d;
         ph_q      <= ph_d;
         ir_q      <= ir_d;
         pc_q      <= pc_d;
         flags_q   <= flags_d;
         bank_q    <= bank_d;
         faddr_q   <= faddr_d;
         taken_q   <= taken_d;
         cyc_q     <= cyc_d;
         mod_q     <= mod_d;
      end
   end

   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [PC_W-1:0] pc_at_q;

   // instruction address held for the target check
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pc_at_q <= PC_W'(`RBS_RST_PC);
      end
      else if (state_q == rbs_pkg::st_run && ph_q == 2'h0)
      begin
         pc_at_q <= pc_q;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_q4;
      state_q == rbs_pkg::st_run && ph_q == 2'h3;
   endsequence
   sequence s_idle_cycle;
      (state_q == rbs_pkg::st_nop)[*4] ##1 (state_q == rbs_pkg::st_idle);
   endsequence

   a_notneg_cond: assert property (s_q4 and ir_q[15:8] == 8'hE7 |=>
      (state_q == rbs_pkg::st_nop) == !$past(flags_q[2]))
      else $error("not-negative branch decision wrong");
   a_notov_cond: assert property (s_q4 and ir_q[15:8] == 8'hE5 |=>
      (state_q == rbs_pkg::st_nop) == !$past(flags_q[1]))
      else $error("not-overflow branch decision wrong");
   a_notzero_cond: assert property (s_q4 and ir_q[15:8] == 8'hE1 |=>
      (state_q == rbs_pkg::st_nop) == !$past(flags_q[0]))
      else $error("not-zero branch decision wrong");
   a_branch_target: assert property ($rose(state_q == rbs_pkg::st_nop) |->
      pc_q == PC_W'(pc_at_q + PC_W'(`RBS_PC_STEP) + ({{(PC_W-11){off[10]}}, off} << 1)))
      else $error("branch target wrong");
   a_cycle_count: assert property ($fell(busy) |-> cyc_q == (taken_q ? 8'h02 : 8'h01))
      else $error("instruction cycle count wrong");
   a_taken_idle: assert property (s_q4 and take |=> s_idle_cycle)
      else $error("taken branch idle cycle wrong");
   a_always_jump: assert property (s_q4 and ir_q[15:11] == 5'h1A |=>
      state_q == rbs_pkg::st_nop)
      else $error("always branch not taken");
   a_always_len: assert property ($rose(busy) and ir_q[15:11] == 5'h1A |->
      busy[*8] ##1 !busy)
      else $error("always branch length wrong");
   sequence s_q3_set;
      state_q == rbs_pkg::st_run && ph_q == 2'h2 && is_set;
   endsequence
   // written byte is the byte read in Q3 with the chosen bit forced
   a_set_bit: assert property (s_q3_set |=>
      dm.wr && dm.wdata == ($past(dm.rdata) | (8'h01 << ir_q[11:9])))
      else $error("bit set value wrong");
   a_bank_sel: assert property (busy && is_set && ir_q[8] |-> dm.addr[AW-1:8] == bank_q)
      else $error("bank select not used");
   a_set_flags: assert property ($rose(busy) and is_set |->
      ($stable(flags_q) && busy)[*4] ##1 !busy)
      else $error("bit set length or flags wrong");
   a_fetch_step: assert property (state_q == rbs_pkg::st_run && ph_q == 2'h0 |=>
      pc_q == $past(pc_q) + PC_W'(2))
      else $error("fetch address step wrong");
endmodule

// *** logic/rbs_defs.svh ***
`ifndef RBS_DEFS_SVH
`define RBS_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RBS_OFS_INSTR 8'h00
`define RBS_OFS_PC    8'h04
`define RBS_OFS_FLAGS 8'h08
`define RBS_OFS_BANK  8'h0C
`define RBS_OFS_STAT  8'h10
`define RBS_OFS_FADDR 8'h14
`define RBS_OFS_FDATA 8'h18
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RBS_FLG_Z       0
`define RBS_FLG_OV      1
`define RBS_FLG_N       2
`define RBS_RST_PC      32'h0000_0000
`define RBS_RST_FLAGS   3'h0
`define RBS_RST_BANK    4'h0
`define RBS_RST_FADDR   12'h000
`define RBS_ACC_SPLIT   8'h80
`define RBS_ACC_HI_BANK 4'hF
`define RBS_PC_STEP     2
// ----------------------------------------
// opcodes and responses
// ----------------------------------------
`define RBS_OP_NOTNEG  8'hE7
`define RBS_OP_NOTOV   8'hE5
`define RBS_OP_NOTZERO 8'hE1
`define RBS_OP_ALWAYS  5'h1A
`define RBS_OP_SETBIT  4'h8
`define RBS_RESP_OKAY  2'h0
`define RBS_RESP_SLV   2'h2
`endif

// *** logic/rbs_pkg.sv ***
package rbs_pkg;
   // execution sequencer states
   typedef enum logic [1:0]
   {
      st_idle = 2'h0,
      st_run  = 2'h1,
      st_nop  = 2'h2
   } rbs_state_e;
   typedef logic [7:0] rbs_byte_t;
endpackage

// *** logic/rbs_dmem_if.sv ***
`timescale 1ns/1ps
interface rbs_dmem_if #(parameter int AW = 12);
   logic [AW-1:0]      addr;
   logic               wr;
   rbs_pkg::rbs_byte_t wdata;
   rbs_pkg::rbs_byte_t rdata;
   modport core (output addr, output wr, output wdata, input rdata);
   modport mem (input addr, input wr, input wdata, output rdata);
endinterface

// *** logic/rbs_dmem.sv ***
`timescale 1ns/1ps
module rbs_dmem #(
   parameter int AW = 12
) (
   input wire logic aclk,
   rbs_dmem_if.mem  port
);
   rbs_pkg::rbs_byte_t ram [0:(1<<AW)-1];
   rbs_pkg::rbs_byte_t rdata_q;

   // file register array, registered read
   always_ff @(posedge aclk)
   begin
      if (port.wr)
      begin
         ram[port.addr] <= port.wdata;
      end
      rdata_q <= ram[port.addr];
   end

   assign port.rdata = rdata_q;
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`include "rbs_defs.svh"
module tb_top;
   // ----------------------------------------
   // table row: start state, instruction, expected outcome
   // ----------------------------------------
   typedef struct packed
   {
      logic [20:0] pc;
      logic [2:0]  flg;
      logic [15:0] ins;
      logic [20:0] pc_exp;
      logic        tk_exp;
      logic [7:0]  cyc_exp;
   } rbs_row_s;
   localparam int N_ROWS = 10;
   rbs_row_s rows [N_ROWS] = '{
      '{21'h000100, 3'h0, 16'hE705, 21'h00010C, 1'b1, 8'h02},
      '{21'h000100, 3'h4, 16'hE705, 21'h000102, 1'b0, 8'h01},
      '{21'h000100, 3'h5, 16'hE580, 21'h000002, 1'b1, 8'h02},
      '{21'h000100, 3'h2, 16'hE580, 21'h000102, 1'b0, 8'h01},
      '{21'h000100, 3'h6, 16'hE17F, 21'h000200, 1'b1, 8'h02},
      '{21'h000100, 3'h1, 16'hE17F, 21'h000102, 1'b0, 8'h01},
      '{21'h001000, 3'h7, 16'hD3FF, 21'h001800, 1'b1, 8'h02},
      '{21'h001000, 3'h0, 16'hD400, 21'h000802, 1'b1, 8'h02},
      '{21'h000100, 3'h0, 16'hE6FF, 21'h000102, 1'b0, 8'h01},
      '{21'h000100, 3'h7, 16'h8000, 21'h000102, 1'b0, 8'h01}};
   // ----------------------------------------
   // clock, bus signals, design
   // ----------------------------------------
   logic        aclk;
   logic        aresetn;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   int          fails;
   int          samples_checked;
   logic [31:0] d;
   logic [1:0]  r;
   rbs_core dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // free running clock, 100 ns period
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // ----------------------------------------
   // compare, verdict
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // axi4-lite master cycles
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic done;
      done = 1'b0;
      rs = 2'h3;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // only the watchdog ends a wait for the answer
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            rs = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic done;
      done = 1'b0;
      rs = 2'h3;
      v = 32'hX;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   // write expecting okay
   task automatic wok(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      wr(a, v, rs);
      check({30'h0, rs}, {30'h0, `RBS_RESP_OKAY});
   endtask
   // read expecting okay
   task automatic rok(input logic [7:0] a, output logic [31:0] v);
      logic [1:0] rs;
      rd(a, v, rs);
      check({30'h0, rs}, {30'h0, `RBS_RESP_OKAY});
   endtask
   // start an instruction and poll busy until it clears
   task automatic run(input logic [15:0] ins);
      logic [31:0] s;
      int          k;
      wok(`RBS_OFS_INSTR, {16'h0, ins});
      s = 32'h1;
      k = 0;
      while (s[0] !== 1'b0 && k < 30)
      begin
         rok(`RBS_OFS_STAT, s);
         k++;
      end
      check({31'h0, s[0]}, 32'h0);
   endtask
   // file register access through the window
   task automatic fput(input logic [11:0] fa, input logic [7:0] v);
      wok(`RBS_OFS_FADDR, {20'h0, fa});
      wok(`RBS_OFS_FDATA, {24'h0, v});
   endtask
   task automatic fget(input logic [11:0] fa, output logic [31:0] v);
      wok(`RBS_OFS_FADDR, {20'h0, fa});
      rok(`RBS_OFS_FDATA, v);
   endtask
   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   // hang guard, well beyond the expected run
   initial
   begin
      #(100 * 20000);
      fails++;
      stop_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      fails = 0;
      samples_checked = 0;
      aresetn = 1'b0;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      do_reset();
      // bus outputs settled at their reset levels
      @(negedge aclk);
      check({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h1C);
      check(rdata, 32'h0);
      check({28'h0, bresp, rresp}, 32'h0);
      // reset values and unmapped read
      rok(`RBS_OFS_PC, d);
      check(d, 32'h0);
      rok(`RBS_OFS_FLAGS, d);
      check(d, 32'h0);
      rok(`RBS_OFS_BANK, d);
      check(d, 32'h0);
      rok(`RBS_OFS_STAT, d);
      check({31'h0, d[0]}, 32'h0);
      rd(8'h1C, d, r);
      check({30'h0, r}, {30'h0, `RBS_RESP_SLV});
      check(d, 32'h0);
      // file register the last table row sets a bit in
      fput(12'h000, 8'h00);
      // table of branch and fall-through cases
      foreach (rows[i])
      begin
         wok(`RBS_OFS_FLAGS, {29'h0, rows[i].flg});
         wok(`RBS_OFS_PC, {11'h0, rows[i].pc});
         run(rows[i].ins);
         rok(`RBS_OFS_PC, d);
         check(d, {11'h0, rows[i].pc_exp});
         rok(`RBS_OFS_STAT, d);
         check({31'h0, d[1]}, {31'h0, rows[i].tk_exp});
         check({24'h0, d[15:8]}, {24'h0, rows[i].cyc_exp});
      end
      fget(12'h000, d);
      check(d, 32'h01);
      // bit set: access bank low and high halves, bank select value
      fput(12'h005, 8'h0A);
      fput(12'h305, 8'h00);
      fput(12'hF90, 8'h00);
      wok(`RBS_OFS_BANK, 32'h3);
      wok(`RBS_OFS_FLAGS, 32'h5);
      run(16'h8E05);
      fget(12'h005, d);
      check(d, 32'h8A);
      fget(12'h305, d);
      check(d, 32'h00);
      run(16'h8105);
      fget(12'h305, d);
      check(d, 32'h01);
      fget(12'h005, d);
      check(d, 32'h8A);
      run(16'h8490);
      fget(12'hF90, d);
      check(d, 32'h04);
      rok(`RBS_OFS_FLAGS, d);
      check(d, 32'h5);
      rok(`RBS_OFS_STAT, d);
      check({24'h0, d[15:8]}, 32'h1);
      // writes and window reads refused while a taken branch runs
      wok(`RBS_OFS_FLAGS, 32'h0);
      wok(`RBS_OFS_PC, 32'h100);
      wok(`RBS_OFS_INSTR, 32'hE705);
      wr(`RBS_OFS_FLAGS, 32'h4, r);
      check({30'h0, r}, {30'h0, `RBS_RESP_SLV});
      rd(`RBS_OFS_FDATA, d, r);
      check({30'h0, r}, {30'h0, `RBS_RESP_SLV});
      run(16'hE6FF);
      rok(`RBS_OFS_FLAGS, d);
      check(d, 32'h0);
      rok(`RBS_OFS_PC, d);
      check(d, 32'h10E);
      // status is read only, unmapped write refused
      wok(`RBS_OFS_STAT, 32'hFFFF);
      rok(`RBS_OFS_STAT, d);
      check({31'h0, d[0]}, 32'h0);
      wr(8'h1C, 32'h1, r);
      check({30'h0, r}, {30'h0, `RBS_RESP_SLV});
      // reset in mid-run clears the address
      wok(`RBS_OFS_PC, 32'h55A);
      wok(`RBS_OFS_INSTR, 32'hE705);
      do_reset();
      rok(`RBS_OFS_PC, d);
      check(d, 32'h0);
      rok(`RBS_OFS_STAT, d);
      check(d, 32'h0);
      stop_test();
   end
endmodule
